// *** common/pss_pkg.sv ***
// Purpose: Shared constants and types for the power source selector.
// Assumes: A 50 MHz core clock and 32-bit APB register access.
// Notes: All delay counts derive from the printed times and the clock rate.
package pss_pkg;

	localparam longint unsigned CLOCK_HZ = 64'd50_000_000;
	localparam int CNT_W = 34;

	localparam longint unsigned T_DEGLITCH_SHORT_MS = 64'd150;
	localparam longint unsigned T_DEGLITCH_LONG_MS = 64'd1300;
	localparam longint unsigned T_GATE_CHECK_MS = 64'd20;
	localparam longint unsigned T_RETRY_MS = 64'd1300;
	localparam longint unsigned T_FAIL_WINDOW_S = 64'd90;
	localparam longint unsigned T_WDOG_SHORT_S = 64'd44;
	localparam longint unsigned T_WDOG_MID_S = 64'd88;
	localparam longint unsigned T_WDOG_LONG_S = 64'd175;

	localparam longint unsigned DEGLITCH_SHORT_CYC = T_DEGLITCH_SHORT_MS * CLOCK_HZ / 64'd1000;
	localparam longint unsigned DEGLITCH_LONG_CYC = T_DEGLITCH_LONG_MS * CLOCK_HZ / 64'd1000;
	localparam longint unsigned GATE_CHECK_CYC = T_GATE_CHECK_MS * CLOCK_HZ / 64'd1000;
	localparam longint unsigned RETRY_CYC = T_RETRY_MS * CLOCK_HZ / 64'd1000;
	localparam longint unsigned FAIL_WINDOW_CYC = T_FAIL_WINDOW_S * CLOCK_HZ;
	localparam longint unsigned WDOG_SHORT_CYC = T_WDOG_SHORT_S * CLOCK_HZ;
	localparam longint unsigned WDOG_MID_CYC = T_WDOG_MID_S * CLOCK_HZ;
	localparam longint unsigned WDOG_LONG_CYC = T_WDOG_LONG_S * CLOCK_HZ;

	localparam logic [2:0] FAIL_LIMIT = 3'h7;

	// Register map, byte addresses.
	localparam int ADDR_W = 8;
	localparam logic [7:0] OPTION_ADDR = 8'h00;
	localparam logic [7:0] KICK_ADDR = 8'h04;
	localparam logic [7:0] STATUS_ADDR = 8'h08;

	// Option word fields.
	localparam int OPT_INHIBIT = 0;
	localparam int OPT_CAL = 6;
	localparam int OPT_DEPL_LO = 11;
	localparam int OPT_WDOG_LO = 13;
	localparam int OPT_DEGLITCH = 15;
	localparam logic [15:0] OPTION_RESET = 16'he000;
	localparam logic [1:0] WDOG_OFF = 2'h0;
	localparam logic [1:0] WDOG_SHORT = 2'h1;
	localparam logic [1:0] WDOG_MID = 2'h2;

	// Status word fields.
	localparam int ST_GOOD = 0;
	localparam int ST_ADAPTER_SW = 1;
	localparam int ST_BATTERY_SW = 2;
	localparam int ST_CHARGE = 3;
	localparam int ST_LATCH = 4;
	localparam int ST_WDOG = 5;
	localparam int ST_FIRST = 6;
	localparam int ST_FAILS_LO = 8;
	localparam int ST_STATE_LO = 16;

	// Depletion fractions in hundredths of a percent, ascending by code.
	localparam logic [12:0] DEPL_0 = 13'h171f;
	localparam logic [12:0] DEPL_1 = 13'h1879;
	localparam logic [12:0] DEPL_2 = 13'h19ff;
	localparam logic [12:0] DEPL_3 = 13'h1bb9;

	typedef enum logic [7:0] {
		SRC_IDLE = 8'h01,
		SRC_DEGLITCH = 8'h02,
		SRC_HOLD = 8'h04,
		SRC_BREAK = 8'h08,
		SRC_GATE_ON = 8'h10,
		SRC_ADAPTER = 8'h20,
		SRC_RETRY = 8'h40,
		SRC_LATCHED = 8'h80
	} src_state_t;

endpackage

// *** rtl/interval_timer.sv ***
// Purpose: Restartable up-counter that flags when a limit is reached.
// Assumes: Limit is at least one cycle.
// Notes: The flag stays high until the next restart.
`timescale 1ns/10ps
module interval_timer
	import pss_pkg::*;
#(
	parameter int W = CNT_W
) (
	input wire logic clock, // Core clock.
	input wire logic resetn, // Synchronous reset, active low.
	input wire logic restart, // Clears the count and the flag.
	input wire logic enable, // Counts while high.
	input wire logic [W-1:0] limit, // Cycles to the flag.
	output logic expired // Limit reached.
);

	typedef struct packed {
		logic [W-1:0] count;
		logic done;
	} timer_t;

	timer_t s;
	timer_t next_s;

	always_comb begin
		next_s = s;
		if (restart) begin
			next_s.count = '0;
			next_s.done = 1'b0;
		end else if (enable && !s.done) begin
			if (s.count >= limit - W'(1)) begin
				next_s.done = 1'b1;
			end else begin
				next_s.count = s.count + W'(1);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign expired = s.done;

endmodule

// *** rtl/power_source_selector.sv ***
// Purpose: Adapter detection, source selection, calibration discharge and charge gating.
// Assumes: Comparator results arrive already synchronous to clock.
// Notes: Registers are reached over APB with zero wait states.
// Function
// - Adapter good only with supply ok, sense in window, and supply above battery.
// - First adapter good rise after power-on uses the 150 ms delay.
// - Selected 1.3 s or 150 ms deglitch applies only on later rises.
// - Sense below 0.6 V resets logic and forces next deglitch to 1.3 s.
// - Host access only with supply and sense ok; bit 15 zero selects 150 ms.
// - Overvoltage drops adapter good, charge, adapter switch; battery switch may turn on.
// - Sense back in window: adapter good, battery off, then adapter switches on.
// - Battery connects at power-on; selectors change break-before-make.
// - No adapter: adapter switches off; battery switch on when its conditions hold.
// - After deglitch switch to adapter if good and not calibrating or depleted.
// - Gate drive low 20 ms after turn-on turns switches off, retry after 1.3 s.
// - Seven gate failures in 90 s latch switches off until sense reset.
// - Adapter switches off when adapter not good or calibrating above depletion.
// - Option bit 6 set starts calibration: adapter off, battery on.
// - Battery below depletion ends calibration, reconnects adapter, clears bit 6.
// - Bits 12:11 pick depletion threshold from four fractions.
// - Charge starts only when every enable condition holds.
// - Any stop condition ends charging.
// - Watchdog suspends charge without touching registers; rewrite resumes.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps
module power_source_selector
	import pss_pkg::*;
#(
	parameter longint unsigned DEGLITCH_SHORT = DEGLITCH_SHORT_CYC,
	parameter longint unsigned DEGLITCH_LONG = DEGLITCH_LONG_CYC,
	parameter longint unsigned GATE_CHECK = GATE_CHECK_CYC,
	parameter longint unsigned RETRY = RETRY_CYC,
	parameter longint unsigned FAIL_WINDOW = FAIL_WINDOW_CYC,
	parameter longint unsigned WDOG_SHORT_LEN = WDOG_SHORT_CYC,
	parameter longint unsigned WDOG_MID_LEN = WDOG_MID_CYC,
	parameter longint unsigned WDOG_LONG_LEN = WDOG_LONG_CYC
) (
	input wire logic clock, // Core clock, 50 MHz.
	input wire logic resetn, // Power-on reset, synchronous, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction.
	input wire logic [ADDR_W-1:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error.
	input wire logic supply_above_undervoltage_lockout, // Supply above undervoltage_lockout.
	input wire logic battery_above_undervoltage_lockout, // battery_sense_neg above undervoltage_lockout.
	input wire logic sense_above_reset, // adapter_sense above 0.6 V.
	input wire logic sense_above_low, // adapter_sense above 2.4 V.
	input wire logic adapter_overvoltage, // adapter_sense above 3.15 V.
	input wire logic supply_above_battery, // Supply exceeds battery by 275 mV.
	input wire logic adapter_battery_compare, // Adapter within 200 mV above battery.
	input wire logic battery_present, // A battery is attached.
	input wire logic gate_drive_ok, // Adapter switch gate-source above 5.9 V.
	input wire logic battery_below_depletion, // Battery below selected threshold.
	input wire logic current_limit_input_above_start, // current_limit_input above 105 mV.
	input wire logic current_limit_input_above_stop, // current_limit_input above 75 mV.
	input wire logic [2:0] limit_dac_valid, // Each limit DAC holds a valid value.
	input wire logic battery_overvoltage, // Battery overvoltage.
	input wire logic thermal_shutdown, // Die over temperature.
	input wire logic input_overcurrent, // Input overcurrent detected.
	input wire logic short_circuit, // Inductor or switch short detected.
	output logic adapter_good, // Adapter good flag.
	output logic adapter_switch, // Adapter and reverse_block_switch enable.
	output logic battery_switch, // battery_switch enable.
	output logic charge_enable, // Converter may charge.
	output logic [1:0] depletion_select, // Depletion threshold code.
	output logic [12:0] depletion_fraction // Threshold in hundredths of a percent.
);

	typedef struct packed {
		src_state_t state;
		logic [15:0] option;
		logic good;
		logic first_rise;
		logic adapter_sw;
		logic battery_sw;
		logic charge;
		logic current_limit_input_ok;
		logic wdog_expired;
		logic [2:0] fails;
		logic [1:0] depl_sel;
		logic [12:0] depl_frac;
		logic [31:0] rdata;
		logic ready;
		logic err;
	} core_t;

	core_t s;
	core_t next_s;

	logic seq_expired;
	logic seq_restart;
	logic [CNT_W-1:0] seq_limit;
	logic window_expired;
	logic window_restart;
	logic wdog_hit;
	logic wdog_restart;
	logic wdog_run;
	logic [CNT_W-1:0] wdog_limit;

	function automatic logic [12:0] fraction_of(input logic [1:0] code);
		unique case (code)
			2'h0: fraction_of = DEPL_0;
			2'h1: fraction_of = DEPL_1;
			2'h2: fraction_of = DEPL_2;
			2'h3: fraction_of = DEPL_3;
		endcase
	endfunction

	function automatic logic is_adapter_on(input src_state_t st);
		is_adapter_on = (st == SRC_GATE_ON) || (st == SRC_ADAPTER);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Timers.

	logic adapter_window;
	logic host_ok;
	logic setup_phase;
	logic access_wr;
	logic deglitch_long;

	assign adapter_window = supply_above_undervoltage_lockout && sense_above_low && !adapter_overvoltage
		&& supply_above_battery;
	assign host_ok = supply_above_undervoltage_lockout && sense_above_reset;
	assign setup_phase = psel && !penable;
	assign access_wr = psel && penable && s.ready && pwrite && host_ok;

	assign deglitch_long = !s.first_rise && s.option[OPT_DEGLITCH];

	always_comb begin
		seq_limit = CNT_W'(RETRY);
		unique case (s.state)
			SRC_DEGLITCH: seq_limit = deglitch_long ? CNT_W'(DEGLITCH_LONG) : CNT_W'(DEGLITCH_SHORT);
			SRC_GATE_ON: seq_limit = CNT_W'(GATE_CHECK);
			default: seq_limit = CNT_W'(RETRY);
		endcase
	end

	always_comb begin
		unique case (s.option[OPT_WDOG_LO +: 2])
			WDOG_OFF: wdog_limit = CNT_W'(WDOG_LONG_LEN);
			WDOG_SHORT: wdog_limit = CNT_W'(WDOG_SHORT_LEN);
			WDOG_MID: wdog_limit = CNT_W'(WDOG_MID_LEN);
			default: wdog_limit = CNT_W'(WDOG_LONG_LEN);
		endcase
	end

	assign seq_restart = next_s.state != s.state;
	assign window_restart = window_expired || !sense_above_reset;
	assign wdog_restart = access_wr && (paddr == KICK_ADDR || paddr == OPTION_ADDR);
	assign wdog_run = s.option[OPT_WDOG_LO +: 2] != WDOG_OFF;

	interval_timer #(.W(CNT_W)) seq_timer (
		.clock(clock),
		.resetn(resetn),
		.restart(seq_restart),
		.enable(1'b1),
		.limit(seq_limit),
		.expired(seq_expired)
	);

	interval_timer #(.W(CNT_W)) window_timer (
		.clock(clock),
		.resetn(resetn),
		.restart(window_restart),
		.enable(1'b1),
		.limit(CNT_W'(FAIL_WINDOW)),
		.expired(window_expired)
	);

	interval_timer #(.W(CNT_W)) wdog_timer (
		.clock(clock),
		.resetn(resetn),
		.restart(wdog_restart),
		.enable(wdog_run),
		.limit(wdog_limit),
		.expired(wdog_hit)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Source selection, charge gating and register access.

	logic allow_adapter;
	logic gate_fail;
	logic battery_ok;
	logic [31:0] status_word;

	assign allow_adapter = s.good && (!s.option[OPT_CAL] || battery_below_depletion);
	assign gate_fail = (s.state == SRC_GATE_ON) && !gate_drive_ok && seq_expired;
	assign battery_ok = battery_present && supply_above_undervoltage_lockout && battery_above_undervoltage_lockout
		&& adapter_battery_compare;

	always_comb begin
		status_word = '0;
		status_word[ST_GOOD] = s.good;
		status_word[ST_ADAPTER_SW] = s.adapter_sw;
		status_word[ST_BATTERY_SW] = s.battery_sw;
		status_word[ST_CHARGE] = s.charge;
		status_word[ST_LATCH] = s.state == SRC_LATCHED;
		status_word[ST_WDOG] = s.wdog_expired;
		status_word[ST_FIRST] = s.first_rise;
		status_word[ST_FAILS_LO +: 3] = s.fails;
		status_word[ST_STATE_LO +: 8] = s.state;
	end

	always_comb begin
		next_s = s;

		// The option word keeps host writes until a sense reset reloads OPTION_RESET; otherwise hardware clears only the calibration bit.
		if (access_wr && paddr == OPTION_ADDR) begin
			next_s.option = pwdata[15:0];
		end

		// Fail counter: a failure in the clearing cycle still counts as one.
		if (window_expired) begin
			next_s.fails = '0;
		end
		if (gate_fail) begin
			next_s.fails = (window_expired ? 3'h0 : s.fails) + 3'h1;
		end

		unique case (s.state)
			SRC_IDLE: begin
				if (adapter_window) begin
					next_s.state = SRC_DEGLITCH;
				end
			end
			SRC_DEGLITCH: begin
				if (!adapter_window) begin
					next_s.state = SRC_IDLE;
				end else if (seq_expired) begin
					next_s.good = 1'b1;
					next_s.first_rise = 1'b0;
					next_s.state = SRC_HOLD;
				end
			end
			SRC_HOLD: begin
				if (allow_adapter) begin
					if (s.option[OPT_CAL]) begin
						next_s.option[OPT_CAL] = 1'b0;
					end
					next_s.state = SRC_BREAK;
				end
			end
			SRC_BREAK: begin
				next_s.state = allow_adapter ? SRC_GATE_ON : SRC_HOLD;
			end
			SRC_GATE_ON: begin
				if (!allow_adapter) begin
					next_s.state = SRC_HOLD;
				end else if (gate_drive_ok) begin
					next_s.state = SRC_ADAPTER;
				end else if (gate_fail) begin
					next_s.state = (next_s.fails == FAIL_LIMIT) ? SRC_LATCHED : SRC_RETRY;
				end
			end
			SRC_ADAPTER: begin
				if (!allow_adapter) begin
					next_s.state = SRC_HOLD;
				end
			end
			SRC_RETRY: begin
				if (seq_expired) begin
					next_s.state = SRC_HOLD;
				end
			end
			SRC_LATCHED: begin
				next_s.state = SRC_LATCHED;
			end
		endcase

		if (!adapter_window) begin
			next_s.good = 1'b0;
			if (s.state != SRC_LATCHED) begin
				next_s.state = SRC_IDLE;
			end
		end

		if (!sense_above_reset) begin
			next_s.state = SRC_IDLE;
			next_s.option = OPTION_RESET;
			next_s.good = 1'b0;
			next_s.first_rise = 1'b0;
			next_s.fails = '0;
			next_s.wdog_expired = 1'b0;
		end

		next_s.adapter_sw = is_adapter_on(next_s.state) && !s.battery_sw;
		next_s.battery_sw = battery_ok && !s.adapter_sw && !next_s.adapter_sw
			&& !is_adapter_on(next_s.state) && next_s.state != SRC_BREAK;

		if (wdog_restart || !wdog_run) begin
			next_s.wdog_expired = 1'b0;
		end
		// The timer flag stands until its restart, so a kick must not read it as a new expiry.
		if (wdog_hit && wdog_run && !wdog_restart) begin
			next_s.wdog_expired = 1'b1;
		end

		// Current-limit input hysteresis between the start and stop levels.
		if (current_limit_input_above_start) begin
			next_s.current_limit_input_ok = 1'b1;
		end else if (!current_limit_input_above_stop) begin
			next_s.current_limit_input_ok = 1'b0;
		end

		next_s.charge = !next_s.option[OPT_INHIBIT] && next_s.current_limit_input_ok && (&limit_dac_valid)
			&& next_s.good && s.state == SRC_ADAPTER && next_s.state == SRC_ADAPTER
			&& gate_drive_ok && !battery_overvoltage && !thermal_shutdown
			&& !input_overcurrent && !short_circuit && !next_s.wdog_expired;

		next_s.depl_sel = next_s.option[OPT_DEPL_LO +: 2];
		next_s.depl_frac = fraction_of(next_s.option[OPT_DEPL_LO +: 2]);

		// Zero-wait APB: the answer is prepared in the setup cycle.
		next_s.ready = setup_phase;
		next_s.err = 1'b0;
		next_s.rdata = '0;
		if (setup_phase) begin
			if (!host_ok) begin
				next_s.err = 1'b1;
			end else begin
				unique case (paddr)
					OPTION_ADDR: next_s.rdata = {16'h0000, s.option};
					KICK_ADDR: next_s.rdata = '0;
					STATUS_ADDR: next_s.rdata = status_word;
					default: next_s.err = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			s <= '0;
			s.state <= SRC_IDLE;
			s.option <= OPTION_RESET;
			s.first_rise <= 1'b1;
			s.depl_frac <= DEPL_0;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.rdata;
	assign pready = s.ready;
	assign pslverr = s.err;
	assign adapter_good = s.good;
	assign adapter_switch = s.adapter_sw;
	assign battery_switch = s.battery_sw;
	assign charge_enable = s.charge;
	assign depletion_select = s.depl_sel;
	assign depletion_fraction = s.depl_frac;

endmodule

// *** bench/gate_model.sv ***
// Purpose: Gate drive model of the adapter switch pair.
// Assumes: The gate charges a fixed number of cycles after turn-on.
// Notes: A stuck gate never reaches full drive.
`timescale 1ns/10ps
module gate_model #(
	parameter int RISE = 4
) (
	input wire logic clock, // Clock.
	input wire logic adapter_switch, // Gate enable.
	input wire logic stuck, // Gate never charges.
	output logic gate_drive_ok // Full gate drive.
);
	int cnt = 0;
	always @(posedge clock) begin
		cnt <= adapter_switch ? cnt + 1 : 0;
	end
	assign gate_drive_ok = adapter_switch && !stuck && cnt >= RISE;
endmodule

// *** bench/pss_props.sv ***
// Purpose: Port checks for the power source selector.
// Assumes: Bound with the selector's own short counts.
// Notes: Helper counts are 16 bits; runs stay far shorter.
`timescale 1ns/10ps
module pss_props
	import pss_pkg::*;
#(
	parameter longint unsigned DEGLITCH_SHORT = 20,
	parameter longint unsigned GATE_CHECK = 10
) (
	input wire logic clock, // Clock.
	input wire logic resetn, // Reset.
	input wire logic psel, // Select.
	input wire logic penable, // Enable.
	input wire logic pready, // Ready.
	input wire logic pslverr, // Error.
	input wire logic supply_above_undervoltage_lockout, // Supply ok.
	input wire logic battery_above_undervoltage_lockout, // Battery ok.
	input wire logic sense_above_reset, // Sense over reset.
	input wire logic sense_above_low, // Sense over low.
	input wire logic adapter_overvoltage, // Overvoltage.
	input wire logic supply_above_battery, // Not asleep.
	input wire logic battery_present, // Battery.
	input wire logic gate_drive_ok, // Gate drive.
	input wire logic current_limit_input_above_stop, // Limit input.
	input wire logic [2:0] limit_dac_valid, // Limits valid.
	input wire logic battery_overvoltage, // Fault.
	input wire logic thermal_shutdown, // Fault.
	input wire logic input_overcurrent, // Fault.
	input wire logic short_circuit, // Fault.
	input wire logic adapter_good, // Good flag.
	input wire logic adapter_switch, // Adapter pair.
	input wire logic battery_switch, // Battery switch.
	input wire logic charge_enable, // Charge.
	input wire logic [1:0] depletion_select, // Code.
	input wire logic [12:0] depletion_fraction // Fraction.
);
	logic win;
	logic stop;
	logic [15:0] win_cnt;
	logic [15:0] low_cnt;
	assign win = supply_above_undervoltage_lockout && sense_above_low && !adapter_overvoltage
		&& supply_above_battery;
	assign stop = battery_overvoltage || thermal_shutdown || input_overcurrent
		|| short_circuit || !current_limit_input_above_stop || limit_dac_valid != 3'h7;
	// Saturating counts so a long adapter session cannot wrap into a false pass.
	always_ff @(posedge clock) begin
		win_cnt <= (!resetn || !win) ? 16'h0 : win_cnt + {15'h0, win_cnt != 16'hffff};
		low_cnt <= (!resetn || !adapter_switch || gate_drive_ok) ? 16'h0
			: low_cnt + {15'h0, low_cnt != 16'hffff};
	end
	function automatic logic [12:0] frac(input logic [1:0] c);
		return c == 2'h0 ? 13'h171f : c == 2'h1 ? 13'h1879 : c == 2'h2 ? 13'h19ff : 13'h1bb9;
	endfunction
	////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	good_window_a: assert property (!win |=> !adapter_good)
		else $error("good flag outside window");
	good_delay_a: assert property ($rose(adapter_good) |-> 64'(win_cnt) >= DEGLITCH_SHORT)
		else $error("good flag rose early");
	ovp_drop_a: assert property (adapter_overvoltage |=> !adapter_good
		##1 (!adapter_switch && !charge_enable)) else $error("overvoltage not handled");
	break_make_a: assert property ($rose(adapter_switch) |-> !$past(battery_switch))
		else $error("adapter on while battery on");
	make_break_a: assert property ($rose(battery_switch) |-> !$past(adapter_switch))
		else $error("battery on while adapter on");
	no_good_off_a: assert property (!adapter_good |=> !adapter_switch)
		else $error("adapter on without good");
	fault_stop_a: assert property (stop |-> ##[1:2] !charge_enable)
		else $error("charge kept on fault");
	switch_charge_a: assert property (!adapter_switch |=> !charge_enable)
		else $error("charge without adapter");
	gate_limit_a: assert property (64'(low_cnt) <= GATE_CHECK + 64'd3)
		else $error("weak gate kept on");
	host_refuse_a: assert property (psel && !penable
		&& !(supply_above_undervoltage_lockout && sense_above_reset) |=> pready && pslverr)
		else $error("access not refused");
	depl_map_a: assert property ($stable(depletion_select)
		|-> depletion_fraction == frac(depletion_select)) else $error("bad fraction");
	battery_cond_a: assert property (!battery_present || !battery_above_undervoltage_lockout
		|-> ##[1:2] !battery_switch) else $error("battery switch on");
	cover property ($rose(adapter_good));
	cover property ($rose(charge_enable));
	cover property ($rose(battery_switch) && adapter_good);
endmodule

// *** bench/tb_power_source_selector.sv ***
// Purpose: Register and port level tests of the power source selector.
// Assumes: Short counts stand in for the long delays.
// Notes: Registers are reached over APB only.
`timescale 1ns/10ps
module tb_power_source_selector;
	import pss_pkg::*;
	localparam longint unsigned DS = 20, DL = 40, GC = 10, RT = 30, WS = 50;
	logic clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, stuck = 1'b0, gate_drive_ok;
	logic supply_above_undervoltage_lockout = 1'b1, battery_above_undervoltage_lockout = 1'b1, sense_above_reset = 1'b1;
	logic sense_above_low = 1'b0, adapter_overvoltage = 1'b0, supply_above_battery = 1'b1;
	logic adapter_battery_compare = 1'b1, battery_present = 1'b1, battery_below_depletion = 1'b0;
	logic current_limit_input_above_start = 1'b1, current_limit_input_above_stop = 1'b1, battery_overvoltage = 1'b0;
	logic thermal_shutdown = 1'b0, input_overcurrent = 1'b0, short_circuit = 1'b0;
	logic [2:0] limit_dac_valid = 3'h7;
	logic adapter_good, adapter_switch, battery_switch, charge_enable;
	logic [1:0] depletion_select;
	logic [12:0] depletion_fraction;
	logic [12:0] frac [4] = '{13'h171f, 13'h1879, 13'h19ff, 13'h1bb9};
	logic [3:0] obs;
	int errors = 0, total_checks = 0, n;
	assign obs = {charge_enable, battery_switch, adapter_switch, adapter_good};
	always #10 clock = ~clock;
	power_source_selector #(.DEGLITCH_SHORT(DS), .DEGLITCH_LONG(DL), .GATE_CHECK(GC),
		.RETRY(RT), .FAIL_WINDOW(64'd600), .WDOG_SHORT_LEN(WS), .WDOG_MID_LEN(64'd60),
		.WDOG_LONG_LEN(64'd70)) power_source_selector_i (.*);
	gate_model gate_model_i (.clock(clock), .adapter_switch(adapter_switch), .stuck(stuck),
		.gate_drive_ok(gate_drive_ok));
	////////////////////////////////////////
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic crange(input string name, input longint unsigned lo, input longint unsigned hi);
		total_checks++;
		if (64'(n) < lo || 64'(n) > hi) begin
			errors++;
			$display("BAD %s expected %0d to %0d seen %0d", name, lo, hi, n);
		end
	endtask
	// Bounded wait, so a stuck output shows up as a mismatch instead of a hang.
	task automatic wait_obs(input logic [3:0] m, input logic [3:0] v);
		n = 0;
		while ((obs & m) !== v && n < 2000) begin
			@(posedge clock);
			n++;
		end
	endtask
	task automatic expect_obs(input string name, input logic [3:0] m, input logic [3:0] v);
		wait_obs(m, v);
		check(name, {28'h0, v}, {28'h0, obs & m});
	endtask
	task automatic replug(input longint unsigned lo);
		sense_above_low <= 1'b0;
		expect_obs("unplugged", 4'hf, 4'h4);
		sense_above_low <= 1'b1;
		wait_obs(4'h1, 4'h1);
		crange("rise delay", lo, lo + 64'd4);
		expect_obs("replugged", 4'hf, 4'hb);
	endtask
	task automatic fault(input int i, input logic v);
		case (i)
			0: battery_overvoltage <= v;
			1: thermal_shutdown <= v;
			2: input_overcurrent <= v;
			3: short_circuit <= v;
			4: current_limit_input_above_stop <= !v;
			5: limit_dac_valid <= v ? 3'h6 : 3'h7;
			default: apb(1'b1, OPTION_ADDR, {31'h0, v});
		endcase
		if (i == 4) begin
			current_limit_input_above_start <= !v;
		end
	endtask
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#400000;
		errors++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		apb(1'b0, OPTION_ADDR, 32'h0);
		check("option reset", 32'he000, rd);
		apb(1'b0, 8'h0c, 32'h0);
		check("unmapped", 32'h1, {31'h0, err});
		apb(1'b1, OPTION_ADDR, 32'h8000);
		expect_obs("battery at start", 4'hf, 4'h4);
		battery_present <= 1'b0;
		expect_obs("no battery", 4'h4, 4'h0);
		battery_present <= 1'b1;
		sense_above_low <= 1'b1;
		wait_obs(4'h1, 4'h1);
		crange("first rise", DS, DS + 64'd4);
		expect_obs("adapter path", 4'hf, 4'hb);
		$display("Test startup done");
		replug(DL);
		apb(1'b1, OPTION_ADDR, 32'h0);
		replug(DS);
		adapter_overvoltage <= 1'b1;
		expect_obs("overvoltage", 4'hf, 4'h4);
		adapter_overvoltage <= 1'b0;
		expect_obs("overvoltage over", 4'hf, 4'hb);
		$display("Test detection done");
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, OPTION_ADDR, 32'(c) << 11);
			apb(1'b0, OPTION_ADDR, 32'h0);
			check("option back", 32'(c) << 11, rd);
			check("depletion", {19'h0, frac[c]}, {19'h0, depletion_fraction});
			check("depletion code", 32'(c), {30'h0, depletion_select});
		end
		apb(1'b1, OPTION_ADDR, 32'h0040);
		expect_obs("calibrating", 4'hf, 4'h5);
		battery_below_depletion <= 1'b1;
		expect_obs("depleted", 4'hf, 4'hb);
		apb(1'b0, OPTION_ADDR, 32'h0);
		check("calibration bit", 32'h0, rd);
		battery_below_depletion <= 1'b0;
		$display("Test calibration done");
		for (int i = 0; i < 7; i++) begin
			fault(i, 1'b1);
			expect_obs("charge stop", 4'h8, 4'h0);
			fault(i, 1'b0);
			expect_obs("charge again", 4'h8, 4'h8);
		end
		apb(1'b1, OPTION_ADDR, 32'h2000);
		wait_obs(4'h8, 4'h0);
		crange("watchdog", WS - 64'd4, WS + 64'd4);
		apb(1'b0, OPTION_ADDR, 32'h0);
		check("option kept", 32'h2000, rd);
		apb(1'b1, KICK_ADDR, 32'h0);
		expect_obs("kick resumes", 4'h8, 4'h8);
		apb(1'b1, OPTION_ADDR, 32'h0);
		$display("Test charge done");
		sense_above_low <= 1'b0;
		expect_obs("gate drop", 4'h2, 4'h0);
		stuck <= 1'b1;
		sense_above_low <= 1'b1;
		n = 0;
		do begin
			apb(1'b0, STATUS_ADDR, 32'h0);
			n++;
		end while (rd[ST_LATCH] !== 1'b1 && n < 600);
		check("latched", 32'h1, {31'h0, rd[ST_LATCH]});
		repeat (2 * RT) @(posedge clock);
		check("stays off", 32'h0, {28'h0, obs & 4'ha});
		stuck <= 1'b0;
		sense_above_low <= 1'b0;
		sense_above_reset <= 1'b0;
		apb(1'b0, OPTION_ADDR, 32'h0);
		check("blocked access", 32'h1, {31'h0, err});
		sense_above_reset <= 1'b1;
		apb(1'b0, OPTION_ADDR, 32'h0);
		check("option after reset", 32'he000, rd);
		apb(1'b1, OPTION_ADDR, 32'h8000);
		sense_above_low <= 1'b1;
		wait_obs(4'h1, 4'h1);
		crange("reset rise", DL, DL + 64'd4);
		expect_obs("unlatched", 4'hf, 4'hb);
		$display("Test gate and reset done");
		summarize();
	end
endmodule
bind power_source_selector pss_props #(.DEGLITCH_SHORT(DEGLITCH_SHORT),
	.GATE_CHECK(GATE_CHECK)) pss_props_i (.*);
